// ==== bench/charger_sequencer_alerts_bench.sv ====
// Bench for csa_core: register tasks, alert response reads, sequencer timing.
// Assumes the SMBus host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module charger_sequencer_alerts_bench;
  import csa_pkg::*;
  localparam int unsigned MSC  = 1;
  localparam int unsigned RMC  = 8;
  localparam logic [6:0]  OWNA = 7'h35; // Arbitrary bus address
  localparam logic [1:0]  SH [5] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h1};
  localparam logic [1:0]  SL [5] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h1};
  localparam logic [15:0] CE [5] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h0010};
  logic        clk, rstn, regWr, regRd, telemetryValid, bsrDone, batBelowTrickle, batStable, batOpen;
  logic        batShort, sdaOut, sdaOe, alertOut, alertOe, trickleEn, detectLoadEn, chargerEn;
  logic        sclLine, hostOe, rivalOe;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, regRdData, vinMeas, voutMeas, vbatMeas, thermMeas;
  logic [15:0] bsrMeas, dieTempMeas, ibatMeas, iinMeas;
  logic [1:0]  strapPinLow, strapPinHigh;
  logic [5:0]  chargeStatus, ccTargetMv;
  logic [4:0]  chargeCode;
  wire logic   sdaWire;
  int          nFail, cmpCount;
  assign sdaWire = !(sdaOe || hostOe || rivalOe);
  csa_core #(.RAMP_CYC(RMC), .MS_CYC(MSC), .OWN_ADDR(OWNA)) dut_u (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .sclIn(sclLine), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .alertOut(alertOut), .alertOe(alertOe), .strapPinLow(strapPinLow), .strapPinHigh(strapPinHigh),
    .vinMeas(vinMeas), .voutMeas(voutMeas), .vbatMeas(vbatMeas), .thermMeas(thermMeas), .bsrMeas(bsrMeas),
    .dieTempMeas(dieTempMeas), .ibatMeas(ibatMeas), .iinMeas(iinMeas), .telemetryValid(telemetryValid),
    .bsrDone(bsrDone), .chargeStatus(chargeStatus), .batBelowTrickle(batBelowTrickle),
    .batStable(batStable), .batOpen(batOpen), .batShort(batShort), .trickleEn(trickleEn),
    .detectLoadEn(detectLoadEn), .chargerEn(chargerEn), .chargeCode(chargeCode), .ccTargetMv(ccTargetMv));
  csa_smbus_host host_u (.sclOut(sclLine), .hostOe(hostOe), .rivalOe(rivalOe), .sdaWire(sdaWire));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic completeRun;
    if (nFail == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Settled sampling point after an edge's updates
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= {idx, 2'h0};
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] idx, output logic [15:0] v);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= {idx, 2'h0};
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic tel(input logic [15:0] m);
    @(posedge clk);
    {vinMeas, voutMeas, vbatMeas, thermMeas} <= {4{m}};
    {bsrMeas, dieTempMeas, ibatMeas, iinMeas} <= {4{m}};
    telemetryValid <= 1'b1;
    bsrDone        <= 1'b1;
    @(posedge clk);
    telemetryValid <= 1'b0;
    bsrDone        <= 1'b0;
  endtask
  task automatic waitPhase(input int b, input int lim);
    logic [15:0] v;
    for (int i = 0; i < lim; i++) begin
      rd(REG_PHASE, v);
      if (v[b]) break;
    end
    chk(v, 16'h1 << b);
  endtask
  initial begin
    logic [15:0] v;
    logic [7:0]  b;
    logic        a;
    int          n;
    {rstn, regWr, regRd, telemetryValid, bsrDone, batOpen, batShort} = '0;
    {regAddr, regWrData, chargeStatus} = '0;
    {vinMeas, voutMeas, vbatMeas, thermMeas, bsrMeas, dieTempMeas, ibatMeas, iinMeas} = '0;
    {strapPinHigh, strapPinLow, batBelowTrickle, batStable} = {2'h2, 2'h1, 1'b1, 1'b1};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    wr(REG_EN_PHASE, 16'h0020);
    wr(6'h3F, 16'hFFFF);
    rd(6'h3F, v);
    chk(v, 16'h0000);
    wr(REG_LIMIT_LAST, 16'hABCD);
    rd(REG_LIMIT_LAST, v);
    chk(v, 16'hABCD);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      strapPinHigh <= SH[k];
      strapPinLow  <= SL[k];
      repeat (8) tick();
      rd(REG_CELL, v);
      chk((k < 4) ? v : (v & 16'h0010), CE[k]);
    end
    chk({15'h0, trickleEn}, 16'h0);
    @(posedge clk);
    {strapPinHigh, strapPinLow} <= {2'h2, 2'h1};
    repeat (10) tick();
    chk({15'h0, trickleEn}, 16'h1);
    @(posedge clk);
    batBelowTrickle <= 1'b0;
    for (n = 0; n < 20 && detectLoadEn !== 1'b1; n++) tick();
    for (n = 0; n < 5000 && detectLoadEn === 1'b1; n++) tick();
    chk(16'(n + 2 >= DET_LOAD_MS * MSC && n <= DET_LOAD_MS * MSC + 2), 16'h1);
    waitPhase(PH_FLOAT, 2000);
    rd(REG_PHASE_ALERTS, v);
    chk(v, 16'h0020);
    chk({15'h0, alertOe}, 16'h1);
    wr(REG_EN_STATUS, 16'h0002);
    @(posedge clk);
    chargeStatus <= 6'h02;
    repeat (4) tick();
    rd(REG_STATUS_ALERTS, v);
    chk(v, 16'h0002);
    wr(REG_PHASE_ALERTS, 16'hFFDF);
    wr(REG_STATUS_ALERTS, 16'hFFFD);
    tick();
    chk({15'h0, alertOe}, 16'h0);
    wr(REG_CHG_CTRL, 16'h001F);
    for (n = 0; n < 400 && chargeCode !== 5'h1F; n++) tick();
    chk({11'h0, chargeCode}, 16'h001F);
    chk({10'h0, ccTargetMv}, 16'h0020);
    wr(REG_CHG_CTRL, 16'h0000);
    for (n = 0; n < 400 && chargeCode !== 5'h00; n++) tick();
    chk(16'(n >= 30 * RMC && n <= 32 * RMC), 16'h1);
    chk({10'h0, ccTargetMv}, 16'h0001);
    wr(REG_LIMIT_FIRST, 16'h1000);
    wr(6'h02, 16'h3000);
    wr(REG_EN_LIMIT, 16'h0001);
    tel(16'h2000);
    rd(REG_LIMIT_ALERTS, v);
    chk(v, 16'h0001);
    chk({15'h0, alertOe}, 16'h1);
    wr(REG_LIMIT_ALERTS, 16'hFFFF);
    rd(REG_LIMIT_ALERTS, v);
    chk(v, 16'h0001);
    host_u.araRead(1'b1, b, a);
    chk({8'h0, b}, 16'h0041);
    chk({15'h0, alertOe}, 16'h1);
    host_u.araRead(1'b0, b, a);
    chk({a, 7'h0, b}, {1'b1, 7'h0, OWNA, 1'b1});
    tick();
    chk({15'h0, alertOe}, 16'h0);
    wr(REG_LIMIT_ALERTS, 16'hFFFE);
    wr(REG_CHG_CTRL, 16'h0020);
    repeat (20) tick();
    @(posedge clk);
    batStable <= 1'b0;
    batOpen   <= 1'b1;
    wr(REG_CHG_CTRL, 16'h0000);
    waitPhase(PH_MISSING, 4000);
    chk({15'h0, chargerEn}, 16'h0);
    for (n = 0; n < 40000 && detectLoadEn !== 1'b1; n++) tick();
    chk(16'(n + 20 >= RETRY_MS * MSC && n <= RETRY_MS * MSC + 20), 16'h1);
    completeRun();
  end
  initial begin
    repeat (80000) @(posedge clk);
    nFail++;
    completeRun();
  end
endmodule // charger_sequencer_alerts_bench
`default_nettype wire

// ==== bench/csa_core_assertions.sv ====
// Checker on the csa_core ports: bus idle, SDA timing, ramp steps, straps.
// Assumes one clock domain and that it is bound to every csa_core.
`timescale 1ns/100ps
`default_nettype none
module csa_core_assertions
  import csa_pkg::*;
#(
  parameter int unsigned RAMP_CYC = 8
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  input wire logic        sclIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        alertOut,
  input wire logic        alertOe,
  input wire logic [1:0]  strapPinLow,
  input wire logic [1:0]  strapPinHigh,
  input wire logic        batBelowTrickle,
  input wire logic        trickleEn,
  input wire logic        detectLoadEn,
  input wire logic        chargerEn,
  input wire logic [4:0]  chargeCode,
  input wire logic [5:0]  ccTargetMv
);
  logic        strapBad;
  logic [31:0] gap;
  logic [4:0]  prevCode;
  assign strapBad = !({strapPinHigh, strapPinLow} inside {4'hA, 4'h9, 4'h8, 4'h6});
  // Cycles the applied code has held still
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap      <= 32'h0;
      prevCode <= 5'h0;
    end else begin
      prevCode <= chargeCode;
      gap      <= (chargeCode != prevCode) ? 32'h0 : gap + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  open_drain_a: assert property (alertOut == 1'b0 && sdaOut == 1'b0)
    else $error("pin driven high");
  sda_alert_a: assert property (sdaOe |-> alertOe)
    else $error("SDA driven without alert");
  sda_scl_a: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("SDA moved while SCL high");
  code_step_a: assert property ($changed(chargeCode) |->
    chargeCode == $past(chargeCode) + 5'h1 || chargeCode == $past(chargeCode) - 5'h1)
    else $error("code jumped");
  ramp_gap_a: assert property ($changed(chargeCode) |-> gap >= RAMP_CYC - 1)
    else $error("ramp step too early");
  cc_target_a: assert property ($past(rstn) |-> ccTargetMv inside {[6'h01:6'h20]})
    else $error("target out of range");
  trickle_cause_a: assert property (trickleEn |-> batBelowTrickle && !chargerEn)
    else $error("trickle without low battery");
  detect_load_a: assert property (detectLoadEn |-> !trickleEn)
    else $error("load during trickle");
  strap_inhibit_a: assert property (strapBad [*6] |=> !chargerEn && !trickleEn && !detectLoadEn)
    else $error("charging with bad straps");
  rd_idle_a: assert property (!$past(regRd) |-> regRdData == 16'h0)
    else $error("read data outside slot");
  cover property ($rose(sdaOe));
  cover property ($fell(alertOe));
  cover property ($changed(chargeCode));
  cover property (trickleEn);
endmodule // csa_core_assertions
bind csa_core csa_core_assertions #(.RAMP_CYC(RAMP_CYC)) chk_u (
  .clk(clk), .rstn(rstn), .regRd(regRd), .regRdData(regRdData), .sclIn(sclIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .alertOut(alertOut), .alertOe(alertOe),
  .strapPinLow(strapPinLow), .strapPinHigh(strapPinHigh), .batBelowTrickle(batBelowTrickle),
  .trickleEn(trickleEn), .detectLoadEn(detectLoadEn), .chargerEn(chargerEn),
  .chargeCode(chargeCode), .ccTargetMv(ccTargetMv));
`default_nettype wire

// ==== bench/csa_smbus_host.sv ====
// SMBus host issuing alert response reads, with an optional rival responder.
// Assumes an SDA wire with pull-up resolved by the bench; SCL idles high.
`timescale 1ns/100ps
`default_nettype none
module csa_smbus_host
  import csa_pkg::*;
(
  output logic      sclOut,
  output logic      hostOe,
  output logic      rivalOe,
  input  wire logic sdaWire
);
  // Lower address than the device, so it always wins
  localparam logic [7:0] RIVAL_READ = 8'h41;
  initial begin
    sclOut  = 1'b1;
    hostOe  = 1'b0;
    rivalOe = 1'b0;
  end
  // 64 ns bit: SDA moves only while SCL is low
  task automatic bitCycle(input logic drv, input logic rv, output logic smp);
    #8 hostOe = !drv;
    rivalOe = !rv;
    #24 sclOut = 1'b1;
    #16 smp = sdaWire;
    #16 sclOut = 1'b0;
  endtask
  task automatic araRead(input logic rival, output logic [7:0] got, output logic acked);
    logic s;
    hostOe = 1'b1;
    #16 sclOut = 1'b0;
    for (int i = 7; i >= 0; i--) bitCycle(ARA_READ[i], 1'b1, s);
    bitCycle(1'b1, 1'b1, s);
    acked = !s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, !rival || RIVAL_READ[i], s);
      got[i] = s;
    end
    bitCycle(1'b1, 1'b1, s);
    #8 hostOe = 1'b1;
    #24 sclOut = 1'b1;
    #16 hostOe = 1'b0;
    #32;
  endtask
endmodule // csa_smbus_host
`default_nettype wire

// ==== core/csa_core.sv ====
// Charger sequencer with SMBus alert logic: limit, phase and status
// alerts, alert response read with arbitration, strap decode, battery
// detection with retries, trickle and charge-current ramp.
// Assumes telemetry, comparator and status inputs come from logic on clk;
// straps, scl and sda are asynchronous and synchronised here.
// Operation
// R01 - Enabled alert flag pulls alert line low
// R02 - Answer alert response read with own address
// R03 - Lost arbitration: stop, keep alert asserted
// R04 - Release alert only after full address sent
// R05 - Host repeats response reads until released
// R06 - Writing 0 clears flag, 1 ignored
// R07 - Host clears serviced bit, writes others 1
// R08 - Twelve limits; flag on crossing high/low
// R09 - Phase entry and status change alerts
// R10 - Decode straps into cell code
// R11 - Invalid straps flag error, inhibit charging
// R12 - Detection: load, then small charge, stable proceeds
// R13 - Unstable battery runs open/short test
// R14 - Abnormal result enters blocking fault phase
// R15 - Fault phase retries detection every 30 s
// R16 - Ramp charge code one step per 400 us
// R17 - Same ramp for changes up or down
// R18 - Below 2.5V trickle from internal supply
// R19 - Constant-current target is setting plus one mV
// R20 - Alert held while enabled flag unacknowledged
// R21 - Disabled alert never sets, never asserts line
`timescale 1ns/100ps
`default_nettype none

module csa_core
  import csa_pkg::*;
#(
  parameter int unsigned RAMP_CYC = RAMP_STEP_US * CLK_MHZ,
  parameter int unsigned MS_CYC   = MS_US * CLK_MHZ,
  parameter logic [6:0]  OWN_ADDR = 7'h2A  // Arbitrary bus address
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic             alertOut,
  output logic             alertOe,
  input  wire logic [1:0]  strapPinLow,
  input  wire logic [1:0]  strapPinHigh,
  input  wire logic [15:0] vinMeas,
  input  wire logic [15:0] voutMeas,
  input  wire logic [15:0] vbatMeas,
  input  wire logic [15:0] thermMeas,
  input  wire logic [15:0] bsrMeas,
  input  wire logic [15:0] dieTempMeas,
  input  wire logic [15:0] ibatMeas,
  input  wire logic [15:0] iinMeas,
  input  wire logic        telemetryValid,
  input  wire logic        bsrDone,
  input  wire logic [5:0]  chargeStatus,
  input  wire logic        batBelowTrickle,
  input  wire logic        batStable,
  input  wire logic        batOpen,
  input  wire logic        batShort,
  output logic             trickleEn,
  output logic             detectLoadEn,
  output logic             chargerEn,
  output logic      [4:0]  chargeCode,
  output logic      [5:0]  ccTargetMv
);

  typedef struct packed {
    logic [2:0]             sclS;
    logic [2:0]             sdaS;
    logic                   sclF;
    logic                   sdaF;
    logic [3:0][2:0]        strapS;
    logic [3:0]             strapF;
    logic [NUM_LIMITS-1:0][15:0] limit;
    logic [13:0]            enLim;
    logic [13:0]            limAl;
    logic [5:0]             enPh;
    logic [5:0]             phAl;
    logic [5:0]             enCs;
    logic [5:0]             csAl;
    logic [5:0]             prevCs;
    logic [4:0]             setting;
    logic                   suspend;
    logic [3:0]             cellCode;
    logic                   cellErr;
    csa_phase_t             phase;
    logic                   unstable;
    logic [31:0]            msDiv;
    logic [31:0]            msCnt;
    logic [31:0]            rampCnt;
    logic [4:0]             applied;
    logic [5:0]             ccMv;
    logic                   alertPending;
    csa_bus_t               bus;
    logic [3:0]             bitCnt;
    logic [7:0]             shifter;
    logic                   sdaDrive;
    logic [15:0]            rdData;
  } csa_state_t;

  csa_state_t s;
  csa_state_t next_s;

  function automatic logic [5:0] phase_vec(input csa_phase_t p);
    logic [5:0] v;
    v = '0;
    case (p)
      S_DET_LOAD, S_DET_CHG, S_OPEN_SHORT: v[PH_DETECT] = 1'b1;
      S_FAILED:  v[PH_FAILED] = 1'b1;
      S_MISSING: v[PH_MISSING] = 1'b1;
      S_SHORT:   v[PH_SHORT] = 1'b1;
      S_SUSP:    v[PH_SUSP] = 1'b1;
      S_FLOAT:   v[PH_FLOAT] = 1'b1;
      default:   v = '0;
    endcase
    return v;
  endfunction

  // Three-flop filter: a change counts once stages two and three agree
  function automatic logic filt(input logic [2:0] sh, input logic old);
    return (sh[1] == sh[2]) ? sh[2] : old;
  endfunction

  logic [NUM_LIMITS-1:0][15:0] meas;
  logic [13:0] limSet;
  logic [5:0]  phSet;
  logic [5:0]  csSet;
  logic        msTick;
  logic        sclRise;
  logic        sclFall;
  logic        startCond;
  logic        stopCond;
  logic        araDone;
  logic [4:0]  target;
  logic [5:0]  idx;

  always_comb begin
    next_s = s;
    meas = {vbatMeas, vbatMeas, voutMeas, voutMeas, iinMeas, ibatMeas,
            dieTempMeas, bsrMeas, thermMeas, thermMeas, vinMeas, vinMeas};
    idx = regAddr[7:2];
    araDone = 1'b0;

    // Pin synchronisers
    next_s.sclS = {s.sclS[1:0], sclIn};
    next_s.sdaS = {s.sdaS[1:0], sdaIn};
    next_s.sclF = filt(s.sclS, s.sclF);
    next_s.sdaF = filt(s.sdaS, s.sdaF);
    for (int i = 0; i < 4; i++) begin
      next_s.strapS[i] = {s.strapS[i][1:0], (i < 2) ? strapPinLow[i] : strapPinHigh[i-2]};
      next_s.strapF[i] = filt(s.strapS[i], s.strapF[i]);
    end

    // Strap decode into cell code
    next_s.cellErr = 1'b0;
    case ({s.strapF[3:2], s.strapF[1:0]})                           // R10
      {LVL_INT, LVL_INT}:   next_s.cellCode = CELL_6V;
      {LVL_INT, LVL_LOGIC}: next_s.cellCode = CELL_12V;
      {LVL_INT, LVL_GND}:   next_s.cellCode = CELL_18V;
      {LVL_LOGIC, LVL_INT}: next_s.cellCode = CELL_24V;
      default: begin
        next_s.cellCode = '0;
        next_s.cellErr  = 1'b1;                                     // R11
      end
    endcase

    // Millisecond time base for long waits
    msTick = (s.msDiv == MS_CYC - 1);
    next_s.msDiv = msTick ? '0 : s.msDiv + 32'h1;
    next_s.msCnt = msTick ? s.msCnt + 32'h1 : s.msCnt;

    // Charge sequencer
    case (s.phase)
      S_INHIBIT, S_SUSP: begin
        next_s.phase = S_TRICKLE;
      end
      S_TRICKLE: begin
        if (!batBelowTrickle) begin                                 // R18
          next_s.phase = S_DET_LOAD;
          next_s.msCnt = '0;
          next_s.unstable = 1'b0;
        end
      end
      S_DET_LOAD, S_DET_CHG: begin                                  // R12
        if (!batStable) next_s.unstable = 1'b1;
        if (s.msCnt >= ((s.phase == S_DET_LOAD) ? DET_LOAD_MS : DET_CHG_MS)) begin
          next_s.msCnt = '0;
          if (s.phase == S_DET_LOAD) next_s.phase = S_DET_CHG;
          else if (s.unstable || !batStable) next_s.phase = S_OPEN_SHORT;  // R13
          else next_s.phase = S_FLOAT;
        end
      end
      S_OPEN_SHORT: begin
        if (s.msCnt >= OPEN_SHORT_MS) begin                         // R14
          next_s.msCnt = '0;
          next_s.phase = batOpen ? S_MISSING : (batShort ? S_SHORT : S_FAILED);
        end
      end
      S_MISSING, S_SHORT, S_FAILED: begin
        if (s.msCnt >= RETRY_MS) next_s.phase = S_TRICKLE;         // R15
      end
      S_FLOAT: next_s.phase = S_FLOAT;
      default: next_s.phase = S_INHIBIT;
    endcase
    if (s.cellErr) next_s.phase = S_INHIBIT;                       // R11
    else if (s.suspend) next_s.phase = S_SUSP;

    // Ramp toward target, one step per period either way
    target = (s.phase == S_FLOAT) ? s.setting : '0;
    next_s.rampCnt = (s.rampCnt == RAMP_CYC - 1) ? '0 : s.rampCnt + 32'h1;
    if (s.rampCnt == RAMP_CYC - 1) begin                            // R16
      if (s.applied < target) next_s.applied = s.applied + 5'h01;
      else if (s.applied > target) next_s.applied = s.applied - 5'h01;  // R17
    end
    next_s.ccMv = {1'b0, s.setting} + 6'h01;                        // R19

    // Alert events, gated by their enables
    for (int i = 0; i < NUM_LIMITS; i++) begin                      // R08
      limSet[i] = telemetryValid && (LIMIT_IS_HI[i] ? (meas[i] > s.limit[i])
                                                     : (meas[i] < s.limit[i]));
    end
    limSet[BIT_BSR_DONE]  = bsrDone;
    limSet[BIT_TEL_VALID] = telemetryValid;
    limSet = limSet & s.enLim;                                      // R21
    phSet  = phase_vec(next_s.phase) & ~phase_vec(s.phase) & s.enPh;  // R09
    csSet  = (chargeStatus ^ s.prevCs) & s.enCs;
    next_s.prevCs = chargeStatus;

    // Register access; sticky flag sets win over clears
    if (regWr) begin
      if (idx >= REG_LIMIT_FIRST && idx <= REG_LIMIT_LAST)
        next_s.limit[4'(idx - REG_LIMIT_FIRST)] = regWrData;
      case (idx)
        REG_EN_LIMIT:      next_s.enLim = regWrData[13:0];
        REG_LIMIT_ALERTS:  next_s.limAl = s.limAl & regWrData[13:0];   // R06
        REG_EN_PHASE:      next_s.enPh = regWrData[5:0];
        REG_PHASE_ALERTS:  next_s.phAl = s.phAl & regWrData[5:0];
        REG_EN_STATUS:     next_s.enCs = regWrData[5:0];
        REG_STATUS_ALERTS: next_s.csAl = s.csAl & regWrData[5:0];
        REG_CHG_CTRL: begin
          next_s.setting = regWrData[4:0];
          next_s.suspend = regWrData[CTRL_SUSPEND];
        end
        default: next_s.enLim = next_s.enLim;
      endcase
    end
    next_s.limAl = next_s.limAl | limSet;
    next_s.phAl  = next_s.phAl | phSet;
    next_s.csAl  = next_s.csAl | csSet;

    next_s.rdData = '0;
    if (regRd) begin
      if (idx >= REG_LIMIT_FIRST && idx <= REG_LIMIT_LAST)
        next_s.rdData = s.limit[4'(idx - REG_LIMIT_FIRST)];
      case (idx)
        REG_EN_LIMIT:      next_s.rdData = {2'h0, s.enLim};
        REG_LIMIT_ALERTS:  next_s.rdData = {2'h0, s.limAl};
        REG_EN_PHASE:      next_s.rdData = {10'h000, s.enPh};
        REG_PHASE_ALERTS:  next_s.rdData = {10'h000, s.phAl};
        REG_EN_STATUS:     next_s.rdData = {10'h000, s.enCs};
        REG_STATUS_ALERTS: next_s.rdData = {10'h000, s.csAl};
        REG_PHASE:         next_s.rdData = {10'h000, phase_vec(s.phase)};
        REG_STATUS:        next_s.rdData = {10'h000, s.prevCs};
        REG_CELL:          next_s.rdData = {11'h000, s.cellErr, s.cellCode};
        REG_CHG_CTRL:      next_s.rdData = {10'h000, s.suspend, s.setting};
        REG_APPLIED:       next_s.rdData = {11'h000, s.applied};
        default:           next_s.rdData = next_s.rdData;
      endcase
    end

    // Alert response read on the bus
    sclRise   = !s.sclF && next_s.sclF;
    sclFall   = s.sclF && !next_s.sclF;
    startCond = s.sclF && next_s.sclF && s.sdaF && !next_s.sdaF;
    stopCond  = s.sclF && next_s.sclF && !s.sdaF && next_s.sdaF;
    case (s.bus)
      I_ADDR: begin
        if (sclRise) begin
          next_s.shifter = {s.shifter[6:0], next_s.sdaF};
          next_s.bitCnt = s.bitCnt + 4'h1;
          if (s.bitCnt == 4'h7)
            next_s.bus = ({s.shifter[6:0], next_s.sdaF} == ARA_READ && s.alertPending)
                         ? I_ACK : I_WAIT;                          // R02
        end
      end
      I_ACK: begin
        if (sclFall && !s.sdaDrive) next_s.sdaDrive = 1'b1;
        else if (sclFall) begin
          next_s.shifter = {OWN_ADDR, 1'b1};
          next_s.bitCnt = '0;
          next_s.sdaDrive = !OWN_ADDR[6];
          next_s.bus = I_TX;
        end
      end
      I_TX: begin
        if (sclRise) begin
          if (s.shifter[7] && !next_s.sdaF) begin                   // R03
            next_s.sdaDrive = 1'b0;
            next_s.bus = I_WAIT;
          end else begin
            next_s.bitCnt = s.bitCnt + 4'h1;
            if (s.bitCnt == 4'h7) begin
              araDone = 1'b1;                                       // R04
              next_s.bus = I_WAIT;
            end
          end
        end else if (sclFall) begin
          next_s.shifter = {s.shifter[6:0], 1'b0};
          next_s.sdaDrive = !s.shifter[6];
        end
      end
      I_WAIT: if (sclFall) next_s.sdaDrive = 1'b0;
      I_IDLE: next_s.sdaDrive = 1'b0;
      default: next_s.bus = I_IDLE;
    endcase
    if (startCond) begin
      next_s.bus = I_ADDR;
      next_s.bitCnt = '0;
      next_s.sdaDrive = 1'b0;
    end else if (stopCond) begin
      next_s.bus = I_IDLE;
      next_s.sdaDrive = 1'b0;
    end

    // Pending alert: new event wins over acknowledge or all-clear
    if (araDone || ~|{next_s.limAl & s.enLim, next_s.phAl & s.enPh, next_s.csAl & s.enCs})
      next_s.alertPending = 1'b0;                                   // R20
    if (|{limSet, phSet, csSet}) next_s.alertPending = 1'b1;        // R01
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.sclS <= 3'h7;
      s.sdaS <= 3'h7;
      s.sclF <= 1'b1;
      s.sdaF <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign regRdData    = s.rdData;
  assign sdaOut       = 1'b0;
  assign sdaOe        = s.sdaDrive;
  assign alertOut     = 1'b0;
  assign alertOe      = s.alertPending;                             // R01
  assign trickleEn    = (s.phase == S_TRICKLE) && batBelowTrickle;  // R18
  assign detectLoadEn = (s.phase == S_DET_LOAD);                    // R12
  assign chargerEn    = (s.phase == S_DET_CHG) || (s.phase == S_OPEN_SHORT) || (s.phase == S_FLOAT);
  assign chargeCode   = s.applied;
  assign ccTargetMv   = s.ccMv;

endmodule // csa_core

`default_nettype wire

// ==== core/csa_pkg.sv ====
// Shared constants for the charger sequencer and alert block.
// Assumes a 250 MHz core clock and a word-indexed register map.
package csa_pkg;

  // Clock rate and documented times
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned RAMP_STEP_US  = 400;
  localparam int unsigned MS_US         = 1000;
  localparam int unsigned DET_LOAD_MS   = 1000;
  localparam int unsigned DET_CHG_MS    = 1000;
  localparam int unsigned OPEN_SHORT_MS = 1500;
  localparam int unsigned RETRY_S       = 30;
  localparam int unsigned RETRY_MS      = RETRY_S * 1000;

  // Register indices; byte address is four times the index
  localparam logic [5:0] REG_LIMIT_FIRST   = 6'h01;
  localparam logic [5:0] REG_LIMIT_LAST    = 6'h0C;
  localparam logic [5:0] REG_EN_LIMIT      = 6'h0D;
  localparam logic [5:0] REG_LIMIT_ALERTS  = 6'h0E;
  localparam logic [5:0] REG_EN_PHASE      = 6'h0F;
  localparam logic [5:0] REG_PHASE_ALERTS  = 6'h10;
  localparam logic [5:0] REG_EN_STATUS     = 6'h11;
  localparam logic [5:0] REG_STATUS_ALERTS = 6'h12;
  localparam logic [5:0] REG_PHASE         = 6'h13;
  localparam logic [5:0] REG_STATUS        = 6'h14;
  localparam logic [5:0] REG_CELL          = 6'h15;
  localparam logic [5:0] REG_CHG_CTRL      = 6'h16;
  localparam logic [5:0] REG_APPLIED       = 6'h17;

  localparam int unsigned NUM_LIMITS = 12;
  // Limit index 0..11: vin hi/lo, thermistor hi/lo, bsr hi, die hi,
  // ibat lo, iin hi, vout hi/lo, vbat hi/lo. Set bit = high limit.
  localparam logic [11:0] LIMIT_IS_HI = 12'h5B5;
  localparam int unsigned BIT_BSR_DONE = 12;
  localparam int unsigned BIT_TEL_VALID = 13;

  // Phase bits of the charger state register
  localparam int unsigned PH_DETECT  = 0;
  localparam int unsigned PH_FAILED  = 1;
  localparam int unsigned PH_MISSING = 2;
  localparam int unsigned PH_SHORT   = 3;
  localparam int unsigned PH_SUSP    = 4;
  localparam int unsigned PH_FLOAT   = 5;

  // Control register fields
  localparam int unsigned CTRL_SUSPEND = 5;

  // Three-level strap codes
  localparam logic [1:0] LVL_GND  = 2'h0;
  localparam logic [1:0] LVL_LOGIC = 2'h1;
  localparam logic [1:0] LVL_INT  = 2'h2;

  // Alert response address read byte and cell codes
  localparam logic [7:0] ARA_READ = 8'h19;
  localparam logic [3:0] CELL_6V  = 4'h2;
  localparam logic [3:0] CELL_12V = 4'h4;
  localparam logic [3:0] CELL_18V = 4'h6;
  localparam logic [3:0] CELL_24V = 4'h8;

  typedef enum logic [3:0] {
    S_INHIBIT, S_SUSP, S_TRICKLE, S_DET_LOAD, S_DET_CHG, S_OPEN_SHORT,
    S_FLOAT, S_MISSING, S_SHORT, S_FAILED
  } csa_phase_t;

  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_TX, I_WAIT} csa_bus_t;

endpackage
